// file: hw/spieep_map.vh
// Opcodes, register layouts, reset values and phase lengths of the serial register block
`ifndef SPIEEP_MAP_VH
`define SPIEEP_MAP_VH
// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define SPIEEP_WRITE_ENABLE_CMD 8'h06
`define SPIEEP_WRITE_DISABLE_CMD 8'h04
`define SPIEEP_READ_STATUS_CMD 8'h05
`define SPIEEP_WRITE_STATUS_CONFIG_CMD 8'h01
`define SPIEEP_ARRAY_READ_CMD 8'h03
`define SPIEEP_FAST_SINGLE_READ_CMD 8'h0B
`define SPIEEP_FAST_DUAL_READ_CMD 8'h3B
`define SPIEEP_READ_CONFIG_SAFETY_CMD 8'h15
`define SPIEEP_READ_VOLATILE_REG_CMD 8'h85
`define SPIEEP_WRITE_VOLATILE_REG_CMD 8'h81
`define SPIEEP_CLEAR_SAFETY_FLAGS_CMD 8'h50
// ------------------------------------------------------------
// Phase lengths in serial clocks, minus one
// ------------------------------------------------------------
`define SPIEEP_OPC_LAST 5'h07
`define SPIEEP_ADDR_LAST 5'h17
`define SPIEEP_DUMMY_LAST 5'h07
`define SPIEEP_BYTE_LAST 5'h07
`define SPIEEP_SINGLE_LAST 3'h7
`define SPIEEP_DUAL_LAST 3'h3
// ------------------------------------------------------------
// Register fields
// ------------------------------------------------------------
`define SPIEEP_WIP_BIT 0
`define SPIEEP_WLATCH_BIT 1
`define SPIEEP_STATUS_WRITE_MASK 8'hBE
`define SPIEEP_CONFIG_WRITE_MASK 8'h83
`define SPIEEP_SAFETY_VOLATILE_MASK 8'hFF
`define SPIEEP_BUF_LD_BIT 0
`define SPIEEP_BUF_EN_BIT 1
// ------------------------------------------------------------
// Reset values and underrun fill byte
// ------------------------------------------------------------
`define SPIEEP_STATUS_RST 8'h00
`define SPIEEP_CONFIG_RST 8'h00
`define SPIEEP_SAFETY_RST 8'h00
`define SPIEEP_VOLATILE_RST 8'h01
`define SPIEEP_UNDERRUN_BYTE 8'hFF
// ------------------------------------------------------------
// Array and buffer shape
// ------------------------------------------------------------
`define SPIEEP_MEM_AW 22
`define SPIEEP_FIFO_DEPTH 16
`define SPIEEP_FIFO_AW 4
`endif

// file: hw/spieep_core.v
// Serial command decoder with register file, array read streaming and prefetch buffer
// Behaviour
// [RL1] Opcode 15h loops configuration then safety bytes
// [RL2] Sample input on rise, shift on fall
// [RL3] Opcode 50h clears safety flags at deselect
// [RL4] Clear only after exactly eight opcode bits
// [RL5] Opcode 85h loops volatile register until deselect
// [RL6] Volatile read allowed during busy write cycle
// [RL7] Volatile write changes only buffer enable bit
// [RL8] Volatile write needs write-enable latch set
// [RL9] Volatile write only on byte-boundary deselect
// [RL10] Volatile write takes effect at deselect instantly
// [RL11] Opcode 01h one byte updates status fields
// [RL12] Two bytes update status then configuration
// [RL13] Status write refused without write-enable latch
// [RL14] More than two bytes discards status write
// [RL15] Status write refused during busy write cycle
// [RL16] Status write only on byte-boundary deselect
// [RL17] Opcode 03h, 24-bit address, single line data
// [RL18] Address increments per byte, wraps to zero
// [RL19] Opcode 0Bh adds eight dummy clocks first
// [RL20] Dummy clocks: input ignored, outputs released
// [RL21] Opcode 3Bh outputs two bits per fall
// [RL22] Opcode 06h sets write-enable latch
// [RL23] Unknown opcode ignored until deselect
// [RL24] Host limits clock rate per command
// [RL25] Deselect ends command and releases outputs
`timescale 1ns/100ps
`default_nettype none
`include "spieep_map.vh"

// ------------------------------------------------------------
// Prefetch buffer
// ------------------------------------------------------------
module spieep_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire rst_b,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage, no reset needed
  reg [AW-1:0] wr_ptr_reg; // Next slot to fill
  reg [AW-1:0] rd_ptr_reg; // Next slot to drain
  reg [AW:0] count_reg; // Occupancy, one bit wider than pointers
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write; flush does not touch contents, only pointers and count
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (flush) begin
      // Flush wins so a stale byte never leaks into the next command
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // spieep_fifo

// ------------------------------------------------------------
// Command decoder and register file
// ------------------------------------------------------------
module spieep_core (
  input wire clock,
  input wire rst_b,
  input wire cs_b,
  input wire sck,
  input wire io_line_zero_in,
  output wire io_line_zero_out,
  output wire io_line_zero_oe,
  output wire io_line_one_out,
  output wire io_line_one_oe,
  input wire write_busy,
  input wire [7:0] safety_flag_set,
  input wire buffer_load_done,
  output wire mem_rd_en,
  output wire [`SPIEEP_MEM_AW-1:0] mem_rd_addr,
  input wire [7:0] mem_rd_data,
  output wire [7:0] status_out,
  output wire [7:0] config_out,
  output wire [7:0] safety_out,
  output wire [7:0] volatile_out
);
  // Decoder states
  localparam PH_OPC = 3'd0;
  localparam PH_ADDR = 3'd1;
  localparam PH_DUMMY = 3'd2;
  localparam PH_MEM = 3'd3;
  localparam PH_REG = 3'd4;
  localparam PH_WDATA = 3'd5;
  localparam PH_NODATA = 3'd6;
  localparam PH_IGNORE = 3'd7;
  localparam [7:0] VOL_RST = `SPIEEP_VOLATILE_RST; // Split into bits at reset

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] cs_sync_reg; // Bit 0 is the metastable stage
  reg [2:0] sck_sync_reg; // Third stage only for edge finding
  reg [1:0] din_sync_reg; // Same depth as sck's second stage
  wire cs_high; // Chip deselected
  wire cs_rise; // Deselect event
  wire sck_rise; // Sample edge
  wire sck_fall; // Launch edge
  wire din; // Serial input aligned with sck edges

  // Two flops before any use; the third stage on sck/cs feeds edge detection only
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      din_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_b};
      sck_sync_reg <= {sck_sync_reg[1:0], sck};
      din_sync_reg <= {din_sync_reg[0], io_line_zero_in};
    end
  end

  assign cs_high = cs_sync_reg[1];
  assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign sck_rise = ~cs_high & sck_sync_reg[1] & ~sck_sync_reg[2]; // RL2
  assign sck_fall = ~cs_high & ~sck_sync_reg[1] & sck_sync_reg[2]; // RL2
  assign din = din_sync_reg[1];

  // ------------------------------------------------------------
  // Decoder state
  // ------------------------------------------------------------
  reg [2:0] state_reg; // Command phase
  reg [7:0] op_reg; // Latched opcode
  reg [7:0] in_sh_reg; // Incoming bits
  reg [23:0] addr_sh_reg; // Incoming address
  reg [4:0] cnt_reg; // Bits seen in current phase
  reg [7:0] wbyte0_reg; // First data byte of a write
  reg [7:0] wbyte1_reg; // Second data byte of a write
  reg [1:0] wcnt_reg; // Data bytes received, saturates at 3
  reg [7:0] out_sh_reg; // Outgoing byte
  reg [2:0] ocnt_reg; // Shifts left in outgoing byte
  reg oe_reg; // Outputs driven
  reg alt_reg; // Config/safety alternation
  reg pf_on_reg; // Prefetcher running
  reg [`SPIEEP_MEM_AW-1:0] pf_addr_reg; // Next array address to fetch
  reg pend_reg; // Read issued last cycle
  reg [7:0] status_reg; // Status bits 7:1 stored, WIP from live busy
  reg [7:0] config_reg; // Configuration
  reg [7:0] safety_reg; // Sticky safety flags
  reg buf_en_reg; // Buffer enable
  reg buf_ld_reg; // Buffer loaded
  wire [7:0] opc_full; // Opcode including this edge's bit
  wire [23:0] addr_full; // Address including this edge's bit
  wire [7:0] byte_full; // Data byte including this edge's bit
  wire dual; // Dual output command
  wire load; // New outgoing byte needed
  wire [7:0] reg_byte; // Register byte to send
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_in_ready;
  wire fifo_pop;
  wire issue; // Array fetch this cycle
  wire [7:0] status_view; // Status with live WIP
  wire wlatch_go;
  wire wrdi_go;
  wire clr_go;
  wire scwr_go;
  wire vwr_go;

  assign opc_full = {in_sh_reg[6:0], din};
  assign addr_full = {addr_sh_reg[22:0], din};
  assign byte_full = {in_sh_reg[6:0], din};
  assign dual = (op_reg == `SPIEEP_FAST_DUAL_READ_CMD);
  assign load = sck_fall & (ocnt_reg == 3'h0) & ((state_reg == PH_MEM) | (state_reg == PH_REG));
  assign status_view = {status_reg[7:1], write_busy};

  // Byte chosen for register reads; alternation drives the config/safety loop
  assign reg_byte = (op_reg == `SPIEEP_READ_CONFIG_SAFETY_CMD) ?
                    (alt_reg ? safety_reg : config_reg) :
                    (op_reg == `SPIEEP_READ_VOLATILE_REG_CMD) ? volatile_out : // RL5 RL6
                    status_view;

  // Input shifting, phase sequencing and output shifting
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PH_OPC;
      op_reg <= 8'h00;
      in_sh_reg <= 8'h00;
      addr_sh_reg <= 24'h00_0000;
      cnt_reg <= 5'h00;
      wbyte0_reg <= 8'h00;
      wbyte1_reg <= 8'h00;
      wcnt_reg <= 2'h0;
      out_sh_reg <= 8'h00;
      ocnt_reg <= 3'h0;
      oe_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else if (cs_high) begin
      // Deselect ends everything and releases the lines
      state_reg <= PH_OPC; // RL25
      cnt_reg <= 5'h00;
      wcnt_reg <= 2'h0;
      ocnt_reg <= 3'h0;
      oe_reg <= 1'b0; // RL25
      alt_reg <= 1'b0;
    end else begin
      if (sck_rise) begin
        case (state_reg)
          PH_OPC: begin
            in_sh_reg <= opc_full; // RL2
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `SPIEEP_OPC_LAST) begin
              cnt_reg <= 5'h00;
              op_reg <= opc_full;
              if ((opc_full == `SPIEEP_WRITE_ENABLE_CMD) ||
                  (opc_full == `SPIEEP_WRITE_DISABLE_CMD) ||
                  (opc_full == `SPIEEP_CLEAR_SAFETY_FLAGS_CMD)) begin
                state_reg <= PH_NODATA; // RL4
              end else if ((opc_full == `SPIEEP_WRITE_STATUS_CONFIG_CMD) ||
                           (opc_full == `SPIEEP_WRITE_VOLATILE_REG_CMD)) begin
                state_reg <= PH_WDATA;
              end else if ((opc_full == `SPIEEP_READ_STATUS_CMD) ||
                           (opc_full == `SPIEEP_READ_CONFIG_SAFETY_CMD) ||
                           (opc_full == `SPIEEP_READ_VOLATILE_REG_CMD)) begin
                state_reg <= PH_REG; // RL1 RL5 RL6
              end else if ((opc_full == `SPIEEP_ARRAY_READ_CMD) ||
                           (opc_full == `SPIEEP_FAST_SINGLE_READ_CMD) ||
                           (opc_full == `SPIEEP_FAST_DUAL_READ_CMD)) begin
                state_reg <= PH_ADDR; // RL17
              end else begin
                state_reg <= PH_IGNORE; // RL23
              end
            end
          end
          PH_ADDR: begin
            addr_sh_reg <= addr_full; // RL17
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `SPIEEP_ADDR_LAST) begin
              cnt_reg <= 5'h00;
              // Plain read streams at once; fast reads wait out the dummies
              state_reg <= (op_reg == `SPIEEP_ARRAY_READ_CMD) ? PH_MEM : PH_DUMMY; // RL19
            end
          end
          PH_DUMMY: begin
            // Input value is not looked at here
            cnt_reg <= cnt_reg + 5'h01; // RL20
            if (cnt_reg == `SPIEEP_DUMMY_LAST) begin
              cnt_reg <= 5'h00;
              state_reg <= PH_MEM; // RL19
            end
          end
          PH_WDATA: begin
            in_sh_reg <= byte_full;
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `SPIEEP_BYTE_LAST) begin
              cnt_reg <= 5'h00;
              if (wcnt_reg == 2'h0) begin
                wbyte0_reg <= byte_full;
              end else if (wcnt_reg == 2'h1) begin
                wbyte1_reg <= byte_full;
              end
              if (wcnt_reg != 2'h3) begin
                wcnt_reg <= wcnt_reg + 2'h1; // RL14
              end
            end
          end
          PH_NODATA: begin
            // A ninth bit spoils a no-data command
            state_reg <= PH_IGNORE; // RL4
          end
          default: begin
            // Streaming and ignore phases take no input
            state_reg <= state_reg; // RL23
          end
        endcase
      end
      // Output launch on the falling edge, MSB first
      if (load) begin
        out_sh_reg <= (state_reg == PH_REG) ? reg_byte :
                      (fifo_valid ? fifo_data : `SPIEEP_UNDERRUN_BYTE); // RL2
        ocnt_reg <= dual ? `SPIEEP_DUAL_LAST : `SPIEEP_SINGLE_LAST; // RL21
        oe_reg <= 1'b1;
        alt_reg <= ~alt_reg; // RL1
      end else if (sck_fall && (ocnt_reg != 3'h0)) begin
        out_sh_reg <= dual ? {out_sh_reg[5:0], 2'b00} : {out_sh_reg[6:0], 1'b0}; // RL21
        ocnt_reg <= ocnt_reg - 3'h1;
      end
    end
  end

  // Single mode drives the upper line only; dual adds the lower line
  assign io_line_one_out = out_sh_reg[7]; // RL2
  assign io_line_one_oe = oe_reg & ~cs_high; // RL20 RL25
  assign io_line_zero_out = out_sh_reg[6]; // RL21
  assign io_line_zero_oe = oe_reg & dual & ~cs_high; // RL21 RL25

  // ------------------------------------------------------------
  // Array prefetch
  // ------------------------------------------------------------
  // One fetch in flight at a time: half rate is still far above the
  // link's byte rate, and it keeps the buffer's ready honest
  assign issue = pf_on_reg & fifo_in_ready & ~pend_reg & ~cs_high;
  assign mem_rd_en = issue;
  assign mem_rd_addr = pf_addr_reg;
  assign fifo_pop = load & (state_reg == PH_MEM);

  // Prefetch starts as soon as the address is complete
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pf_on_reg <= 1'b0;
      pf_addr_reg <= {`SPIEEP_MEM_AW{1'b0}};
      pend_reg <= 1'b0;
    end else if (cs_high) begin
      pf_on_reg <= 1'b0; // RL25
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= issue;
      if (sck_rise && (state_reg == PH_ADDR) && (cnt_reg == `SPIEEP_ADDR_LAST)) begin
        pf_on_reg <= 1'b1;
        pf_addr_reg <= addr_full[`SPIEEP_MEM_AW-1:0];
      end else if (issue) begin
        // Natural wrap of the counter returns to zero past the top
        pf_addr_reg <= pf_addr_reg + {{(`SPIEEP_MEM_AW-1){1'b0}}, 1'b1}; // RL18
      end
    end
  end

  spieep_fifo #(
    .WIDTH(8),
    .DEPTH(`SPIEEP_FIFO_DEPTH),
    .AW(`SPIEEP_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .flush(cs_high),
    .in_valid(pend_reg & pf_on_reg),
    .in_ready(fifo_in_ready),
    .in_data(mem_rd_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ------------------------------------------------------------
  // Register execution at deselect
  // ------------------------------------------------------------
  assign wlatch_go = cs_rise & (state_reg == PH_NODATA) &
                     (op_reg == `SPIEEP_WRITE_ENABLE_CMD); // RL22
  assign wrdi_go = cs_rise & (state_reg == PH_NODATA) & (op_reg == `SPIEEP_WRITE_DISABLE_CMD);
  assign clr_go = cs_rise & (state_reg == PH_NODATA) &
                  (op_reg == `SPIEEP_CLEAR_SAFETY_FLAGS_CMD); // RL3 RL4
  assign scwr_go = cs_rise & (state_reg == PH_WDATA) &
                   (op_reg == `SPIEEP_WRITE_STATUS_CONFIG_CMD) &
                   (cnt_reg == 5'h00) & // RL16
                   ((wcnt_reg == 2'h1) | (wcnt_reg == 2'h2)) & // RL14
                   status_reg[`SPIEEP_WLATCH_BIT] & // RL13
                   ~write_busy; // RL15
  assign vwr_go = cs_rise & (state_reg == PH_WDATA) &
                  (op_reg == `SPIEEP_WRITE_VOLATILE_REG_CMD) &
                  (cnt_reg == 5'h00) & (wcnt_reg == 2'h1) & // RL9
                  status_reg[`SPIEEP_WLATCH_BIT]; // RL8

  // Status and configuration, written in the deselect cycle itself
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `SPIEEP_STATUS_RST;
      config_reg <= `SPIEEP_CONFIG_RST;
    end else if (scwr_go) begin
      status_reg <= (wbyte0_reg & `SPIEEP_STATUS_WRITE_MASK) |
                    (status_reg & ~`SPIEEP_STATUS_WRITE_MASK); // RL11
      if (wcnt_reg == 2'h2) begin
        config_reg <= (wbyte1_reg & `SPIEEP_CONFIG_WRITE_MASK) |
                      (config_reg & ~`SPIEEP_CONFIG_WRITE_MASK); // RL12
      end
    end else if (wlatch_go) begin
      status_reg[`SPIEEP_WLATCH_BIT] <= 1'b1; // RL22
    end else if (wrdi_go) begin
      status_reg[`SPIEEP_WLATCH_BIT] <= 1'b0;
    end
  end

  // Safety flags: a new event in the clear cycle survives
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      safety_reg <= `SPIEEP_SAFETY_RST;
    end else begin
      safety_reg <= (safety_reg & ~(clr_go ? `SPIEEP_SAFETY_VOLATILE_MASK : 8'h00)) |
                    safety_flag_set; // RL3
    end
  end

  // Volatile register: only buffer enable is writable, loaded flag follows it
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buf_en_reg <= VOL_RST[`SPIEEP_BUF_EN_BIT];
      buf_ld_reg <= VOL_RST[`SPIEEP_BUF_LD_BIT];
    end else begin
      if (vwr_go) begin
        buf_en_reg <= wbyte0_reg[`SPIEEP_BUF_EN_BIT]; // RL7 RL10
      end
      if (!buf_en_reg) begin
        buf_ld_reg <= 1'b1;
      end
      if (vwr_go && wbyte0_reg[`SPIEEP_BUF_EN_BIT] && !buf_en_reg) begin
        buf_ld_reg <= 1'b0; // RL7
      end
      // Last so a load finishing in the enabling cycle is not lost
      if (buffer_load_done) begin
        buf_ld_reg <= 1'b1;
      end
    end
  end

  assign status_out = status_view;
  assign config_out = config_reg;
  assign safety_out = safety_reg;
  assign volatile_out = {6'h00, buf_en_reg, buf_ld_reg};
endmodule // spieep_core
`default_nettype wire

// file: bench/spieep_props.sv
// Property checker for the serial command block
`timescale 1ns/100ps
`default_nettype none
module spieep_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic io_line_zero_oe,
  input wire logic io_line_one_out,
  input wire logic io_line_one_oe,
  input wire logic write_busy,
  input wire logic [7:0] safety_flag_set,
  input wire logic [7:0] status_out,
  input wire logic [7:0] config_out,
  input wire logic [7:0] safety_out,
  input wire logic [7:0] volatile_out
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Deselect held long enough for the synchroniser to see it
  sequence desel_s;
    $rose(cs_b) ##1 cs_b [*4];
  endsequence
  AST_RELEASE: assert property (desel_s |-> !io_line_one_oe && !io_line_zero_oe)
    else $error("output enable still high after deselect");
  AST_SELECTED: assert property ($rose(io_line_one_oe) |-> !cs_b)
    else $error("output enabled while deselected");
  AST_DUAL: assert property (io_line_zero_oe |-> io_line_one_oe)
    else $error("dual line driven alone");
  // Data may only move while the serial clock is low
  AST_FALL: assert property (io_line_one_oe && $changed(io_line_one_out) |-> !sck)
    else $error("output bit changed with clock high");
  AST_CLEAR: assert property (|($past(safety_out) & ~safety_out) |-> cs_b && $past(cs_b, 2))
    else $error("safety bits cleared while selected");
  AST_STICKY: assert property (|safety_flag_set |=>
    (safety_out & $past(safety_flag_set)) == $past(safety_flag_set))
    else $error("safety flag not set");
  // Loaded flag only drops when buffer enable is switched on
  AST_VOL_RO: assert property (volatile_out[7:2] == 6'h00 &&
    (!$fell(volatile_out[0]) || $rose(volatile_out[1])))
    else $error("read-only volatile bits moved");
  // A status write seen while busy must leave stored bits 7:2 alone
  AST_WIP: assert property ($past(write_busy) |->
    $stable(status_out[7:2]) && !status_out[6])
    else $error("status written during busy cycle");
  AST_CFG: assert property ($changed(config_out) |-> cs_b)
    else $error("configuration changed mid frame");
  AST_VOL_WR: assert property ($changed(volatile_out[1]) |-> cs_b)
    else $error("buffer enable changed mid frame");
endmodule // spieep_props
`default_nettype wire

// file: bench/spieep_host.sv
// Serial host model that frames commands and samples the returned lines
`timescale 1ns/100ps
`default_nettype none
module spieep_host (
  input wire logic clock,
  output var logic cs_b,
  output var logic sck,
  output var logic si,
  input wire logic d0,
  input wire logic d0_oe,
  input wire logic d1,
  input wire logic d1_oe
);
  // Released line shows the inverse, so a stale bit never matches by luck
  wire logic l0 = d0_oe ? d0 : ~d0;
  wire logic l1 = d1_oe ? d1 : ~d1;
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic sel;
    cs_b <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // Long gap after deselect covers sync delay and execution
  task automatic desel;
    repeat (4) @(posedge clock);
    cs_b <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  // Input moves with clock low, returned bits taken at the rise
  task automatic xfer(input logic [7:0] tx, input int n, input logic dual,
    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      si <= tx[7];
      tx = {tx[6:0], 1'b0};
      repeat (4) @(posedge clock);
      sck <= 1'b1;
      if (dual) rx = {rx[5:0], l1, l0};
      else rx = {rx[6:0], l1};
      repeat (4) @(posedge clock);
      sck <= 1'b0;
    end
  endtask
endmodule // spieep_host
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the serial register and array read block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic write_busy = 1'b0;
  logic [7:0] safety_flag_set = 8'h00;
  logic buffer_load_done = 1'b0;
  logic [7:0] mem_rd_data = 8'h00;
  wire logic cs_b, sck, si, d0, d0_oe, d1, d1_oe, mem_rd_en;
  wire logic [21:0] mem_rd_addr;
  wire logic [7:0] status_out, config_out, safety_out, volatile_out;
  logic [7:0] rx;
  int n_errors = 0;
  int checked = 0;
  always #20 clock = ~clock;
  // Array stand-in: one cycle latency, last value inverted each cycle when idle
  function automatic logic [7:0] mb(input logic [21:0] a);
    return a[7:0] ^ a[21:14];
  endfunction
  always @(posedge clock) mem_rd_data <= mem_rd_en ? mb(mem_rd_addr) : ~mem_rd_data;
  spieep_core spieep_core_i (.clock(clock), .rst_b(rst_b), .cs_b(cs_b), .sck(sck),
    .io_line_zero_in(si), .io_line_zero_out(d0), .io_line_zero_oe(d0_oe),
    .io_line_one_out(d1), .io_line_one_oe(d1_oe), .write_busy(write_busy),
    .safety_flag_set(safety_flag_set), .buffer_load_done(buffer_load_done),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .status_out(status_out), .config_out(config_out), .safety_out(safety_out),
    .volatile_out(volatile_out));
  spieep_host spieep_host_i (.clock(clock), .cs_b(cs_b), .sck(sck), .si(si),
    .d0(d0), .d0_oe(d0_oe), .d1(d1), .d1_oe(d1_oe));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic snd(input logic [7:0] b);
    spieep_host_i.xfer(b, 8, 1'b0, rx);
  endtask
  task automatic rcv(input logic dual);
    spieep_host_i.xfer(8'hFF, dual ? 4 : 8, dual, rx);
  endtask
  // Whole frame of n bytes taken from the top of the word
  task automatic frame(input logic [31:0] b, input int n);
    spieep_host_i.sel;
    for (int i = 0; i < n; i++) snd(b[31-8*i -: 8]);
    spieep_host_i.desel;
  endtask
  // Opcode, address and optional dummy byte, left selected
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int dmy);
    spieep_host_i.sel;
    snd(op);
    snd(a[23:16]);
    snd(a[15:8]);
    snd(a[7:0]);
    if (dmy) snd(8'hA5);
  endtask
  task automatic t_status;
    chk(volatile_out, 8'h01);
    safety_flag_set <= 8'hA5;
    @(posedge clock);
    safety_flag_set <= 8'h00;
    frame(32'h0600_0000, 1);
    chk(status_out, 8'h02);
    frame(32'h01BE_8300, 3);
    chk(status_out, 8'hBE);
    chk(config_out, 8'h83);
    spieep_host_i.sel;
    snd(8'h15);
    for (int i = 0; i < 3; i++) begin
      rcv(1'b0);
      chk(rx, i[0] ? 8'hA5 : 8'h83);
    end
    spieep_host_i.desel;
    spieep_host_i.sel;
    spieep_host_i.xfer(8'h50, 7, 1'b0, rx);
    spieep_host_i.desel;
    chk(safety_out, 8'hA5);
    frame(32'h5000_0000, 1);
    chk(safety_out, 8'h00);
  endtask
  task automatic t_volatile;
    spieep_host_i.sel;
    snd(8'h81);
    spieep_host_i.xfer(8'hFF, 4, 1'b0, rx);
    spieep_host_i.desel;
    chk(volatile_out, 8'h01);
    frame(32'h81FF_0000, 2);
    chk(volatile_out, 8'h02);
    buffer_load_done <= 1'b1;
    @(posedge clock);
    buffer_load_done <= 1'b0;
    write_busy <= 1'b1;
    spieep_host_i.sel;
    snd(8'h85);
    rcv(1'b0);
    chk(rx, 8'h03);
    rcv(1'b0);
    chk(rx, 8'h03);
    spieep_host_i.desel;
  endtask
  task automatic t_refuse;
    frame(32'h0100_0000, 2);
    chk(status_out, 8'hBF);
    write_busy <= 1'b0;
    frame(32'h0100_0000, 4);
    chk(status_out, 8'hBE);
    frame(32'h0100_0000, 2);
    chk(status_out, 8'h00);
    chk(config_out, 8'h83);
    frame(32'h8100_0000, 2);
    chk(volatile_out, 8'h03);
    frame(32'h011C_0000, 2);
    chk(status_out, 8'h00);
    frame(32'hFF06_0000, 2);
    chk(status_out, 8'h00);
  endtask
  task automatic t_array;
    rd(8'h03, 24'h3F_FFFE, 0);
    for (int i = 0; i < 3; i++) begin
      rcv(1'b0);
      chk(rx, mb(22'h3F_FFFE + i));
    end
    spieep_host_i.desel;
    rd(8'h0B, 24'h00_0155, 1);
    chk({7'h00, d1_oe}, 8'h00);
    rcv(1'b0);
    chk(rx, 8'h55);
    spieep_host_i.desel;
    rd(8'h3B, 24'h00_02A5, 1);
    chk({7'h00, d0_oe}, 8'h00);
    rcv(1'b1);
    chk(rx, 8'hA5);
    rcv(1'b1);
    chk(rx, 8'hA6);
    spieep_host_i.desel;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_status;
    t_volatile;
    t_refuse;
    t_array;
    conclude;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    conclude;
  end
endmodule // tb_top
bind spieep_core spieep_props spieep_props_i (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
  .sck(sck), .io_line_zero_oe(io_line_zero_oe), .io_line_one_out(io_line_one_out),
  .io_line_one_oe(io_line_one_oe), .write_busy(write_busy),
  .safety_flag_set(safety_flag_set), .status_out(status_out), .config_out(config_out),
  .safety_out(safety_out), .volatile_out(volatile_out));
`default_nettype wire
